// file: verilog/coherency_unit_access_guard.sv
// register bank guarding writes to the coherency unit configuration
// assumes one clock, straps stable around reset release, and a register
// port whose master identifies the writing processor and its security state
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`include "access_guard_cfg.svh"

module coherency_unit_access_guard (
   input  wire  logic                                clock,
   input  wire  logic                                reset_n,
   // register port
   input  wire  logic [`AG_ADDR_W-1:0]               reg_addr,
   input  wire  logic [31:0]                         reg_wdata,
   input  wire  logic                                reg_write,
   input  wire  logic                                reg_read,
   input  wire  access_guard_pkg::cpu_id_t           reg_cpu_id,
   input  wire  logic                                reg_nonsecure,
   output logic [31:0]                               reg_rdata,
   output logic                                      reg_write_dropped,
   // straps and live configuration
   input  wire  logic                                two_master_port_config,
   input  wire  access_guard_pkg::filt_addr_t        filter_start_config_input,
   input  wire  access_guard_pkg::filt_addr_t        filter_end_config_input,
   input  wire  logic                                address_filter_enable,
   // traffic routing toward master port 1
   input  wire  logic [31:0]                         traffic_addr,
   output logic                                      route_to_port1,
   // protected registers held elsewhere in the unit
   input  wire  access_guard_pkg::cpu_id_t           ext_cpu_id,
   input  wire  logic                                ext_nonsecure,
   output logic                                      ext_write_grant,
   // timer and watchdog access
   input  wire  access_guard_pkg::cpu_id_t           timer_cpu_id,
   input  wire  logic                                timer_nonsecure,
   output logic                                      global_timer_grant,
   output logic                                      private_timer_grant,
   output logic                                      private_timer_read_zero,
   // decoded state for the rest of the unit
   output access_guard_pkg::filt_addr_t              filter_start_address,
   output access_guard_pkg::filt_addr_t              filter_end_address,
   output access_guard_pkg::cpu_mask_t               per_cpu_access_mask,
   output logic [`AG_NS_MASK_W-1:0]                  nonsecure_access_mask
);

   ////////////////////////////////////////////////////////////////////////////
   // reset release
   ////////////////////////////////////////////////////////////////////////////

   logic rst_meta_n;
   logic rst_n;

   // two stages so the release never lands near an edge
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_n <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n      <= rst_meta_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // strap capture
   ////////////////////////////////////////////////////////////////////////////

   logic strapped;
   logic two_ports;

   // straps are caught by a clocked load, never by the async reset itself
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         strapped <= 1'b0;
      end else begin
         strapped <= 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         two_ports <= 1'b0;
      end else if (!strapped) begin
         two_ports <= two_master_port_config;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // address decode
   ////////////////////////////////////////////////////////////////////////////

   access_guard_pkg::reg_sel_e sel;

   always_comb begin
      case (reg_addr)
         `AG_OFF_FILT_START: begin
            sel = access_guard_pkg::sel_filt_start;
         end
         `AG_OFF_FILT_END: begin
            sel = access_guard_pkg::sel_filt_end;
         end
         `AG_OFF_ACC_MASK: begin
            sel = access_guard_pkg::sel_acc_mask;
         end
         `AG_OFF_NS_MASK: begin
            sel = access_guard_pkg::sel_ns_mask;
         end
         `AG_OFF_STATUS: begin
            sel = access_guard_pkg::sel_status;
         end
         default: begin
            sel = access_guard_pkg::sel_none;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // permission checks
   ////////////////////////////////////////////////////////////////////////////

   logic bus_secure_grant;
   logic bus_guarded_grant;
   logic mask_locked;

   // (R14) ns register bits gate
   access_checker bus_check (
      .cpu_id        (reg_cpu_id),
      .nonsecure     (reg_nonsecure),
      .acc_mask      (per_cpu_access_mask),
      .ns_reg_mask   (nonsecure_access_mask[`AG_NS_REG_LO +: `AG_NUM_CPUS]),
      .secure_grant  (bus_secure_grant),
      .guarded_grant (bus_guarded_grant)
   );

   // (R15) outside protected registers
   access_checker ext_check (
      .cpu_id        (ext_cpu_id),
      .nonsecure     (ext_nonsecure),
      .acc_mask      (per_cpu_access_mask),
      .ns_reg_mask   (nonsecure_access_mask[`AG_NS_REG_LO +: `AG_NUM_CPUS]),
      .secure_grant  (),
      .guarded_grant (ext_write_grant)
   );

   // (R9) zero mask locks
   assign mask_locked = (per_cpu_access_mask == '0);

   logic wr_filt_start;
   logic wr_filt_end;
   logic wr_acc_mask;
   logic wr_ns_mask;
   logic wr_any_ok;
   logic filter_regs_live;

   // (R4) one port hides filters
   assign filter_regs_live = strapped && two_ports;

   // one enable per register; a refused write raises none and is dropped
   always_comb begin
      wr_filt_start = 1'b0;
      wr_filt_end   = 1'b0;
      wr_acc_mask   = 1'b0;
      wr_ns_mask    = 1'b0;
      if (reg_write) begin
         case (sel)
            access_guard_pkg::sel_filt_start: begin
               // (R4) filter writes need two ports
               wr_filt_start = filter_regs_live && bus_guarded_grant;
            end
            access_guard_pkg::sel_filt_end: begin
               // (R1) (R2) filter end guard
               wr_filt_end = filter_regs_live && bus_guarded_grant;
            end
            access_guard_pkg::sel_acc_mask: begin
               // (R10) mask self guard
               wr_acc_mask = bus_guarded_grant && !mask_locked;
            end
            access_guard_pkg::sel_ns_mask: begin
               // (R11) secure writers only
               wr_ns_mask = !reg_nonsecure && bus_secure_grant;
            end
            default: begin
               // status and unmapped offsets take no write
               wr_ns_mask = 1'b0;
            end
         endcase
      end
   end

   assign wr_any_ok = wr_filt_start || wr_filt_end || wr_acc_mask || wr_ns_mask;

   ////////////////////////////////////////////////////////////////////////////
   // filtering address registers
   ////////////////////////////////////////////////////////////////////////////

   // (R16) start loaded from its pin
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         filter_start_address <= '0;
      end else if (!strapped) begin
         filter_start_address <= filter_start_config_input;
      end else if (wr_filt_start) begin
         filter_start_address <= reg_wdata[`AG_FILT_HI:`AG_FILT_LO];
      end
   end

   // (R6) end loaded from pin
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         filter_end_address <= '0;
      end else if (!strapped) begin
         filter_end_address <= filter_end_config_input;
      end else if (wr_filt_end) begin
         // (R5) upper twelve bits only
         filter_end_address <= reg_wdata[`AG_FILT_HI:`AG_FILT_LO];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // access mask registers
   ////////////////////////////////////////////////////////////////////////////

   // (R8) all ones after reset
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         per_cpu_access_mask <= `AG_ACC_MASK_RESET;
      end else if (wr_acc_mask) begin
         per_cpu_access_mask <= reg_wdata[`AG_NUM_CPUS-1:0];
      end
   end

   // (R18) secure-only after reset
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         nonsecure_access_mask <= `AG_NS_MASK_RESET;
      end else if (wr_ns_mask) begin
         nonsecure_access_mask <= reg_wdata[`AG_NS_MASK_W-1:0];
      end
   end

   // (R17) silent drop flag
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reg_write_dropped <= 1'b0;
      end else begin
         reg_write_dropped <= reg_write && !wr_any_ok;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // routing toward master port 1
   ////////////////////////////////////////////////////////////////////////////

   logic [`AG_FILT_W-1:0] traffic_mb;
   logic                  above_start;
   logic                  below_end;

   assign traffic_mb  = traffic_addr[`AG_FILT_HI:`AG_FILT_LO];
   assign above_start = (traffic_mb >= filter_start_address);
   // (R3) inclusive end compare
   assign below_end   = (traffic_mb <= filter_end_address);

   // (R7) filter only when enabled
   assign route_to_port1 = strapped && two_ports && address_filter_enable
                           && above_start && below_end;

   ////////////////////////////////////////////////////////////////////////////
   // timer and watchdog gating
   ////////////////////////////////////////////////////////////////////////////

   logic [`AG_NUM_CPUS-1:0] gtim_ns_bits;
   logic [`AG_NUM_CPUS-1:0] ptim_ns_bits;
   logic                    gtim_ns_bit;
   logic                    ptim_ns_bit;

   // slice first so the processor index never reaches past its field
   assign gtim_ns_bits = nonsecure_access_mask[`AG_NS_GTIM_LO +: `AG_NUM_CPUS];
   assign ptim_ns_bits = nonsecure_access_mask[`AG_NS_PTIM_LO +: `AG_NUM_CPUS];
   assign gtim_ns_bit  = gtim_ns_bits[timer_cpu_id];
   assign ptim_ns_bit  = ptim_ns_bits[timer_cpu_id];

   // (R12) global timer non-secure gate
   assign global_timer_grant = !timer_nonsecure || gtim_ns_bit;

   // (R13) private timer, watchdog gate
   assign private_timer_grant     = !timer_nonsecure || ptim_ns_bit;
   assign private_timer_read_zero = timer_nonsecure && !ptim_ns_bit;

   // (R14) register access gate
   // non-secure register access is folded into both checker instances above,
   // so a cleared bit blocks writes here and in the outside registers alike

   ////////////////////////////////////////////////////////////////////////////
   // read path
   ////////////////////////////////////////////////////////////////////////////

   logic [31:0] next_rdata;
   logic [31:0] status_word;

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`AG_STAT_LOCKED]    = mask_locked;
      status_word[`AG_STAT_TWO_PORTS] = two_ports;
      status_word[`AG_STAT_FILT_EN]   = address_filter_enable;
      status_word[`AG_STAT_STRAPPED]  = strapped;
   end

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (reg_read) begin
         case (sel)
            access_guard_pkg::sel_filt_start: begin
               // (R4) zero with one port
               if (filter_regs_live) begin
                  next_rdata[`AG_FILT_HI:`AG_FILT_LO] = filter_start_address;
               end
            end
            access_guard_pkg::sel_filt_end: begin
               // (R4) zero with one port
               if (filter_regs_live) begin
                  next_rdata[`AG_FILT_HI:`AG_FILT_LO] = filter_end_address;
               end
            end
            access_guard_pkg::sel_acc_mask: begin
               next_rdata[`AG_NUM_CPUS-1:0] = per_cpu_access_mask;
            end
            access_guard_pkg::sel_ns_mask: begin
               next_rdata[`AG_NS_MASK_W-1:0] = nonsecure_access_mask;
            end
            access_guard_pkg::sel_status: begin
               next_rdata = status_word;
            end
            default: begin
               next_rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   // data stands only in the cycle after the read strobe
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

endmodule

// file: verilog/access_guard_cfg.svh
// constants of the coherency unit access guard: offsets, fields, resets
// assumes a 32-bit register port with byte addresses and four processors
//
// Operation
// (R1) secure filter-end write needs writer mask bit
// (R2) non-secure filter-end write needs both mask bits
// (R3) filter end address is inclusive
// (R4) single master port: filter writes ignored, reads zero
// (R5) filter end in bits 31:20, 1MB granularity
// (R6) filter end loaded from pin at reset exit
// (R7) filter applies only with two ports and filtering
// (R8) access mask bits 3:0, reset all ones
// (R9) all-zero access mask locks mask forever; the code unlocks it at reset, which reloads all ones
// (R10) access mask write guarded like filter registers
// (R11) non-secure mask written only by permitted secure access
// (R12) bits 11:8 gate non-secure global timer access
// (R13) bits 7:4 gate non-secure private timer, watchdog
// (R14) bits 3:0 gate non-secure protected register access
// (R15) protected set includes outside unit registers too
// (R16) filter start loaded from its pin, lower bound
// (R17) rejected writes dropped silently, no error
// (R18) non-secure register access bits reset to zero
`ifndef ACCESS_GUARD_CFG_SVH
`define ACCESS_GUARD_CFG_SVH

`define AG_ADDR_W          8
`define AG_NUM_CPUS        4
`define AG_CPU_ID_W        2

`define AG_OFF_FILT_START  8'h00
`define AG_OFF_FILT_END    8'h04
`define AG_OFF_ACC_MASK    8'h08
`define AG_OFF_NS_MASK     8'h0c
`define AG_OFF_STATUS      8'h10

`define AG_FILT_HI         31
`define AG_FILT_LO         20
`define AG_FILT_W          12

`define AG_ACC_MASK_RESET  4'hf
`define AG_NS_REG_LO       0
`define AG_NS_PTIM_LO      4
`define AG_NS_GTIM_LO      8
`define AG_NS_MASK_W       12
`define AG_NS_MASK_RESET   12'h000

`define AG_STAT_LOCKED     0
`define AG_STAT_TWO_PORTS  1
`define AG_STAT_FILT_EN    2
`define AG_STAT_STRAPPED   3

`endif

// file: verilog/access_guard_pkg.sv
// types shared by the access guard modules
// assumes access_guard_cfg.svh is on the include path
`include "access_guard_cfg.svh"

package access_guard_pkg;

   typedef logic [`AG_CPU_ID_W-1:0] cpu_id_t;
   typedef logic [`AG_NUM_CPUS-1:0] cpu_mask_t;
   typedef logic [`AG_FILT_W-1:0]   filt_addr_t;

   typedef enum logic [2:0] {
      sel_none       = 3'b000,
      sel_filt_start = 3'b001,
      sel_filt_end   = 3'b010,
      sel_acc_mask   = 3'b011,
      sel_ns_mask    = 3'b100,
      sel_status     = 3'b101
   } reg_sel_e;

endpackage

// file: verilog/access_checker.sv
// per-processor permission decode for protected accesses
// assumes masks come from flip-flops; purely combinational
`timescale 1ns/100ps
`include "access_guard_cfg.svh"

module access_checker (
   input  wire access_guard_pkg::cpu_id_t   cpu_id,
   input  wire logic                        nonsecure,
   input  wire access_guard_pkg::cpu_mask_t acc_mask,
   input  wire access_guard_pkg::cpu_mask_t ns_reg_mask,
   output logic                             secure_grant,
   output logic                             guarded_grant
);

   access_guard_pkg::cpu_mask_t sec_ok;
   access_guard_pkg::cpu_mask_t ns_ok;
   access_guard_pkg::cpu_mask_t sel;

   genvar g;
   generate
      for (g = 0; g < `AG_NUM_CPUS; g = g + 1) begin : per_cpu
         assign sel[g]    = (cpu_id == access_guard_pkg::cpu_id_t'(g));
         // (R1) secure needs own bit
         assign sec_ok[g] = sel[g] & acc_mask[g];
         // (R2) non-secure needs both
         assign ns_ok[g]  = sel[g] & acc_mask[g] & ns_reg_mask[g];
      end
   endgenerate

   assign secure_grant  = |sec_ok;
   assign guarded_grant = nonsecure ? |ns_ok : |sec_ok;

endmodule

// file: test/coherency_unit_access_guard_properties.sv
// checker for the coherency unit access guard, bound to its top module
// assumes access_guard_cfg.svh and the package are compiled before it
`timescale 1ns/100ps
`include "access_guard_cfg.svh"

module coherency_unit_access_guard_checker (
   input wire logic                        clock,
   input wire logic                        reset_n,
   input wire logic [`AG_ADDR_W-1:0]       reg_addr,
   input wire logic [31:0]                 reg_wdata,
   input wire logic                        reg_write,
   input wire logic                        reg_read,
   input wire access_guard_pkg::cpu_id_t   reg_cpu_id,
   input wire logic                        reg_nonsecure,
   input wire logic [31:0]                 reg_rdata,
   input wire logic                        reg_write_dropped,
   input wire logic                        address_filter_enable,
   input wire logic [31:0]                 traffic_addr,
   input wire logic                        route_to_port1,
   input wire access_guard_pkg::cpu_id_t   ext_cpu_id,
   input wire logic                        ext_nonsecure,
   input wire logic                        ext_write_grant,
   input wire access_guard_pkg::cpu_id_t   timer_cpu_id,
   input wire logic                        timer_nonsecure,
   input wire logic                        global_timer_grant,
   input wire logic                        private_timer_read_zero,
   input wire access_guard_pkg::filt_addr_t filter_start_address,
   input wire access_guard_pkg::filt_addr_t filter_end_address,
   input wire access_guard_pkg::cpu_mask_t  per_cpu_access_mask,
   input wire logic [`AG_NS_MASK_W-1:0]    nonsecure_access_mask
);
   logic guard_ok;
   assign guard_ok = per_cpu_access_mask[reg_cpu_id]
                     && (!reg_nonsecure || nonsecure_access_mask[reg_cpu_id]);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
////////////////////////////////////////////////////////////////////////////////
   property p_reset_masks;
      $rose(reset_n) |-> per_cpu_access_mask == 4'hf && nonsecure_access_mask == 12'h000;
   endproperty
   a_reset_masks: assert property (p_reset_masks) else $error("mask reset wrong");
   property p_end_guard;
      reg_write && reg_addr == `AG_OFF_FILT_END && !guard_ok |=> $stable(filter_end_address);
   endproperty
   a_end_guard: assert property (p_end_guard) else $error("filter end changed");
   property p_acc_guard;
      reg_write && reg_addr == `AG_OFF_ACC_MASK && !guard_ok |=> $stable(per_cpu_access_mask);
   endproperty
   a_acc_guard: assert property (p_acc_guard) else $error("mask changed by denied cpu");
   property p_acc_write;
      reg_write && reg_addr == `AG_OFF_ACC_MASK && guard_ok && per_cpu_access_mask != 4'h0
      |=> per_cpu_access_mask == $past(reg_wdata[3:0]);
   endproperty
   a_acc_write: assert property (p_acc_write) else $error("mask write lost");
   // zero mask never leaves zero until reset
   property p_lock;
      per_cpu_access_mask == 4'h0 |=> per_cpu_access_mask == 4'h0;
   endproperty
   a_lock: assert property (p_lock) else $error("locked mask changed");
   property p_ns_guard;
      reg_write && reg_addr == `AG_OFF_NS_MASK
      && (reg_nonsecure || !per_cpu_access_mask[reg_cpu_id])
      |=> $stable(nonsecure_access_mask) && reg_write_dropped;
   endproperty
   a_ns_guard: assert property (p_ns_guard) else $error("ns mask write not dropped");
   property p_end_low;
      $past(reg_read) && $past(reg_addr) == `AG_OFF_FILT_END |-> reg_rdata[19:0] == 20'h0;
   endproperty
   a_end_low: assert property (p_end_low) else $error("filter end low bits set");
   property p_route;
      route_to_port1 |-> address_filter_enable && traffic_addr[31:20] >= filter_start_address
                         && traffic_addr[31:20] <= filter_end_address;
   endproperty
   a_route: assert property (p_route) else $error("route outside range");
   property p_ext;
      ext_write_grant == (per_cpu_access_mask[ext_cpu_id]
                          && (!ext_nonsecure || nonsecure_access_mask[ext_cpu_id]));
   endproperty
   a_ext: assert property (p_ext) else $error("outside register grant wrong");
   property p_gtim;
      global_timer_grant == (!timer_nonsecure || nonsecure_access_mask[8 + timer_cpu_id]);
   endproperty
   a_gtim: assert property (p_gtim) else $error("global timer grant wrong");
   property p_ptim;
      private_timer_read_zero == (timer_nonsecure && !nonsecure_access_mask[4 + timer_cpu_id]);
   endproperty
   a_ptim: assert property (p_ptim) else $error("private timer read zero wrong");
endmodule

bind coherency_unit_access_guard coherency_unit_access_guard_checker u_checker (
   .clock, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_cpu_id,
   .reg_nonsecure, .reg_rdata, .reg_write_dropped, .address_filter_enable, .traffic_addr,
   .route_to_port1, .ext_cpu_id, .ext_nonsecure, .ext_write_grant, .timer_cpu_id,
   .timer_nonsecure, .global_timer_grant, .private_timer_read_zero, .filter_start_address,
   .filter_end_address, .per_cpu_access_mask, .nonsecure_access_mask);

// file: test/testbench.sv
// self-checking bench for the coherency unit access guard
// assumes the design, its package and the checker are compiled before it
`timescale 1ns/100ps
`include "access_guard_cfg.svh"

module testbench;
   logic                          clock, reset_n, reg_write, reg_read, reg_nonsecure;
   logic                          two_master_port_config, address_filter_enable;
   logic                          ext_nonsecure, timer_nonsecure, reg_write_dropped;
   logic                          route_to_port1, ext_write_grant, global_timer_grant;
   logic                          private_timer_grant, private_timer_read_zero;
   logic [7:0]                    reg_addr;
   logic [31:0]                   reg_wdata, reg_rdata, traffic_addr;
   logic [11:0]                   nonsecure_access_mask;
   access_guard_pkg::cpu_id_t     reg_cpu_id, ext_cpu_id, timer_cpu_id;
   access_guard_pkg::cpu_mask_t   per_cpu_access_mask;
   access_guard_pkg::filt_addr_t  filter_start_address, filter_end_address;
   access_guard_pkg::filt_addr_t  filter_start_config_input = 12'h100;
   access_guard_pkg::filt_addr_t  filter_end_config_input = 12'h1ff;
   int                            fails, compares;

   coherency_unit_access_guard dut (.clock, .reset_n, .reg_addr, .reg_wdata, .reg_write,
      .reg_read, .reg_cpu_id, .reg_nonsecure, .reg_rdata, .reg_write_dropped,
      .two_master_port_config, .filter_start_config_input, .filter_end_config_input,
      .address_filter_enable, .traffic_addr, .route_to_port1, .ext_cpu_id, .ext_nonsecure,
      .ext_write_grant, .timer_cpu_id, .timer_nonsecure, .global_timer_grant,
      .private_timer_grant, .private_timer_read_zero, .filter_start_address,
      .filter_end_address, .per_cpu_access_mask, .nonsecure_access_mask);

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      if (fails == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // straps are sampled at reset exit, so a new port count needs a new reset
   task automatic restart(input logic two);
      @(posedge clock);
      reset_n <= 1'b0;
      two_master_port_config <= two;
      repeat (4) @(posedge clock);
      reset_n <= 1'b1;
      repeat (4) @(posedge clock);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] c,
                     input logic ns, input logic drop);
      @(posedge clock);
      {reg_addr, reg_wdata, reg_cpu_id, reg_nonsecure, reg_write} <= {a, d, c, ns, 1'b1};
      @(posedge clock);
      reg_write <= 1'b0;
      #1 chk({31'h0, reg_write_dropped}, {31'h0, drop});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock);
      {reg_addr, reg_cpu_id, reg_nonsecure, reg_read} <= {a, 2'h0, 1'b0, 1'b1};
      @(posedge clock);
      reg_read <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask
   task automatic route(input logic [31:0] a, input logic en, input logic exp);
      @(posedge clock);
      {traffic_addr, address_filter_enable} <= {a, en};
      @(posedge clock);
      #1 chk({31'h0, route_to_port1}, {31'h0, exp});
   endtask
   task automatic perm(input logic [1:0] c, input logic ns, input logic [3:0] exp);
      @(posedge clock);
      {timer_cpu_id, timer_nonsecure, ext_cpu_id, ext_nonsecure} <= {c, ns, c, ns};
      @(posedge clock);
      #1 chk({28'h0, global_timer_grant, private_timer_grant, private_timer_read_zero,
              ext_write_grant}, {28'h0, exp});
   endtask
////////////////////////////////////////////////////////////////////////////////
   initial begin
      {reset_n, reg_write, reg_read, reg_nonsecure, two_master_port_config} = 5'h0;
      {address_filter_enable, ext_nonsecure, timer_nonsecure} = 3'h0;
      {reg_addr, reg_wdata, traffic_addr} = 72'h0;
      {reg_cpu_id, ext_cpu_id, timer_cpu_id} = 6'h0;
      {fails, compares} = 64'h0;
      restart(1'b1);
      rd(`AG_OFF_FILT_END, 32'h1ff0_0000);
      rd(`AG_OFF_FILT_START, 32'h1000_0000);
      rd(`AG_OFF_ACC_MASK, 32'h0000_000f);
      rd(`AG_OFF_NS_MASK, 32'h0000_0000);
      rd(`AG_OFF_STATUS, 32'h0000_000a);
      route(32'h1ff0_0000, 1'b1, 1'b1);
      route(32'h1000_0000, 1'b1, 1'b1);
      route(32'h2000_0000, 1'b1, 1'b0);
      route(32'h0ff0_0000, 1'b1, 1'b0);
      route(32'h1ff0_0000, 1'b0, 1'b0);
      perm(2'h2, 1'b1, 4'b0010);
      perm(2'h2, 1'b0, 4'b1101);
      wr(`AG_OFF_NS_MASK, 32'h0000_0444, 2'h0, 1'b0, 1'b0);
      perm(2'h2, 1'b1, 4'b1101);
      perm(2'h1, 1'b1, 4'b0010);
      wr(`AG_OFF_NS_MASK, 32'h0000_0fff, 2'h2, 1'b1, 1'b1);
      rd(`AG_OFF_NS_MASK, 32'h0000_0444);
      wr(`AG_OFF_FILT_END, 32'hfffc_0000, 2'h2, 1'b1, 1'b0);
      rd(`AG_OFF_FILT_END, 32'hfff0_0000);
      route(32'hffff_ffff, 1'b1, 1'b1);
      wr(`AG_OFF_FILT_START, 32'h2000_0000, 2'h2, 1'b1, 1'b0);
      rd(`AG_OFF_FILT_START, 32'h2000_0000);
      wr(`AG_OFF_FILT_END, 32'h4000_0000, 2'h1, 1'b1, 1'b1);
      rd(`AG_OFF_FILT_END, 32'hfff0_0000);
      wr(`AG_OFF_ACC_MASK, 32'h0000_000e, 2'h0, 1'b0, 1'b0);
      wr(`AG_OFF_FILT_END, 32'h5000_0000, 2'h0, 1'b0, 1'b1);
      wr(`AG_OFF_NS_MASK, 32'h0000_0000, 2'h0, 1'b0, 1'b1);
      wr(`AG_OFF_ACC_MASK, 32'h0000_000f, 2'h1, 1'b1, 1'b1);
      wr(`AG_OFF_ACC_MASK, 32'h0000_0000, 2'h2, 1'b1, 1'b0);
      wr(`AG_OFF_ACC_MASK, 32'h0000_000f, 2'h3, 1'b0, 1'b1);
      rd(`AG_OFF_ACC_MASK, 32'h0000_0000);
      rd(`AG_OFF_STATUS, 32'h0000_000f);
      wr(`AG_OFF_STATUS, 32'h0000_0000, 2'h0, 1'b0, 1'b1);
      perm(2'h3, 1'b0, 4'b1100);
      rd(8'h20, 32'h0000_0000);
      wr(8'h20, 32'h0000_0001, 2'h0, 1'b0, 1'b1);
      restart(1'b0);
      wr(`AG_OFF_FILT_END, 32'h6000_0000, 2'h0, 1'b0, 1'b1);
      rd(`AG_OFF_FILT_END, 32'h0000_0000);
      rd(`AG_OFF_FILT_START, 32'h0000_0000);
      route(32'h1000_0000, 1'b1, 1'b0);
      stop_test();
   end
endmodule
